/* File: include/psr_defs.svh */
// Register offsets, field positions, writable masks and reset values
// Assumes inclusion by bare name from design files
`ifndef PSR_DEFS_SVH
`define PSR_DEFS_SVH

`define PSR_OFS_PERIPH_RST  12'h044
`define PSR_OFS_PORT_RST    12'h048
`define PSR_OFS_CAP_B       12'h04c
`define PSR_OFS_CAP_D       12'h050

`define PSR_BIT_ASYNC0      0
`define PSR_BIT_ASYNC1      1
`define PSR_BIT_SYNC0       4
`define PSR_BIT_ENC0        8
`define PSR_BIT_CNT0        16
`define PSR_BIT_CNT1        17
`define PSR_BIT_CNT2        18
`define PSR_BIT_ACMP0       24

`define PSR_BIT_PORT_A      0
`define PSR_BIT_PORT_B      1
`define PSR_BIT_PORT_C      2
`define PSR_BIT_PORT_D      3
`define PSR_BIT_PORT_E      4

`define PSR_PERIPH_RW_MASK  32'h0107_0113
`define PSR_PORT_RW_MASK    32'h0000_001f
`define PSR_RESET_VAL       32'h0000_0000
`define PSR_CAP_B_DEFAULT   32'h0107_0113
`define PSR_CAP_D_DEFAULT   32'h0000_001f

`endif

/* File: include/psr_pkg.sv */
// Types shared by the soft reset register bank
// Assumes the defines header is compiled alongside
package psr_pkg;
   typedef logic [31:0] psr_word_t;
   typedef enum logic [1:0] {
      PSR_IDLE   = 2'b01,
      PSR_ACCESS = 2'b10
   } psr_phase_e;
endpackage : psr_pkg

/* File: src/psr_apb_slave.sv */
// APB slave front end: decodes one access, answers with zero wait states
// Assumes an APB master on the same clock
`timescale 1ns/1ps
`default_nettype none
module psr_apb_slave (
   // Clock and reset
   input  wire logic        i_core_clk,
   input  wire logic        i_nrst,
   // APB
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [11:0] i_paddr,
   // Decoded strobes
   output logic             o_wr_en,
   output logic             o_rd_en,
   output logic [11:0]      o_addr
);
   psr_pkg::psr_phase_e phase_q;

   // Phase tracking; writes only commit in an access phase after a setup
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         phase_q <= psr_pkg::PSR_IDLE;
      end else if (i_psel && !i_penable) begin
         phase_q <= psr_pkg::PSR_ACCESS;
      end else begin
         phase_q <= psr_pkg::PSR_IDLE;
      end
   end

   assign o_wr_en = i_psel && i_penable && i_pwrite && (phase_q == psr_pkg::PSR_ACCESS);
   assign o_rd_en = i_psel && !i_penable && !i_pwrite;
   assign o_addr  = {i_paddr[11:2], 2'b00};
endmodule : psr_apb_slave
`default_nettype wire

/* File: src/psr_mask_reg.sv */
// One reset control register whose writes are gated by a capability mask
// Assumes write strobe from the APB decoder on the same clock
`timescale 1ns/1ps
`default_nettype none
`include "psr_defs.svh"
module psr_mask_reg #(
   parameter logic [31:0] RW_MASK = 32'h0000_0000
) (
   // Clock and reset
   input  wire logic        i_core_clk,
   input  wire logic        i_nrst,
   // Write side
   input  wire logic        i_we,
   input  wire logic [31:0] i_wdata,
   input  wire logic [31:0] i_cap,
   // Register value
   output logic [31:0]      o_val
);
   logic [31:0] val_q;
   logic [31:0] val_d;

   // Only implemented, non-reserved bits accept writes
   assign val_d = i_wdata & i_cap & RW_MASK;

   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         val_q <= `PSR_RESET_VAL;
      end else if (i_we) begin
         val_q <= val_d;
      end
   end

   assign o_val = val_q;
endmodule : psr_mask_reg
`default_nettype wire

/* File: src/psr_top.sv */
// Peripheral soft reset register bank on APB
// Assumes APB master on i_core_clk; unit resets consumed on the same clock
`timescale 1ns/1ps
`default_nettype none
`include "psr_defs.svh"

// Function
// - Writes to the peripheral reset register are ANDed with capability mask b.
// - Writes to the port reset register are ANDed with capability mask d.
// - Bit 4 of peripheral register resets sync serial zero, resets to 0.
// - Bit 1 of peripheral register resets async serial one, resets to 0.
// - Bit 0 of peripheral register resets async serial zero, resets to 0.
// - Port register bits 4..0 reset ports E..A, each resetting to 0.
// - Reserved bits are read-only zero; writes to them do nothing.
module psr_top (
   // Clock and reset
   input  wire logic        i_core_clk,
   input  wire logic        i_nrst,
   // APB
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [11:0] i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic [31:0]      o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   // Unit resets, active high
   output logic             o_comparator_zero_reset,
   output logic             o_gp_counter_zero_reset,
   output logic             o_gp_counter_one_reset,
   output logic             o_gp_counter_two_reset,
   output logic             o_encoder_unit_reset,
   output logic             o_sync_serial_zero_reset,
   output logic             o_async_serial_one_reset,
   output logic             o_async_serial_zero_reset,
   output logic [4:0]       o_io_port_reset
);
   ////////////////////////////////////////////////////////////////////////////
   logic        wr_en;
   logic        rd_en;
   logic [11:0] addr;
   logic [31:0] periph_val;
   logic [31:0] port_val;
   logic [31:0] prdata_d;
   logic        hit;
   logic        wr_periph;
   logic        wr_port;
   logic        wr_cap_b;
   logic        wr_cap_d;
   logic        port_a_q;
   logic        port_b_q;
   logic        port_c_q;
   logic        port_d_q;
   logic        port_e_q;
   psr_pkg::psr_word_t capability_mask_b_q;
   psr_pkg::psr_word_t capability_mask_d_q;

   psr_apb_slave u_apb (
      .i_core_clk (i_core_clk),
      .i_nrst     (i_nrst),
      .i_psel     (i_psel),
      .i_penable  (i_penable),
      .i_pwrite   (i_pwrite),
      .i_paddr    (i_paddr),
      .o_wr_en    (wr_en),
      .o_rd_en    (rd_en),
      .o_addr     (addr)
   );

   // Write strobes, one per register
   assign wr_periph = wr_en && (addr == `PSR_OFS_PERIPH_RST);
   assign wr_port   = wr_en && (addr == `PSR_OFS_PORT_RST);
   assign wr_cap_b  = wr_en && (addr == `PSR_OFS_CAP_B);
   assign wr_cap_d  = wr_en && (addr == `PSR_OFS_CAP_D);

   ////////////////////////////////////////////////////////////////////////////
   // Capability masks, writable so software can describe the fitted units
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         capability_mask_b_q <= `PSR_CAP_B_DEFAULT;
      end else if (wr_cap_b) begin
         capability_mask_b_q <= i_pwdata & `PSR_PERIPH_RW_MASK;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         capability_mask_d_q <= `PSR_CAP_D_DEFAULT;
      end else if (wr_cap_d) begin
         capability_mask_d_q <= i_pwdata & `PSR_PORT_RW_MASK;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Reset control registers
   psr_mask_reg #(.RW_MASK(`PSR_PERIPH_RW_MASK)) u_periph (
      .i_core_clk (i_core_clk),
      .i_nrst     (i_nrst),
      .i_we       (wr_periph),
      .i_wdata    (i_pwdata),
      .i_cap      (capability_mask_b_q),
      .o_val      (periph_val)
   );

   psr_mask_reg #(.RW_MASK(`PSR_PORT_RW_MASK)) u_port (
      .i_core_clk (i_core_clk),
      .i_nrst     (i_nrst),
      .i_we       (wr_port),
      .i_wdata    (i_pwdata),
      .i_cap      (capability_mask_d_q),
      .o_val      (port_val)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Unit reset outputs follow register bits one cycle later
   // Analog comparator zero
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_comparator_zero_reset <= 1'b0;
      end else begin
         o_comparator_zero_reset <= periph_val[`PSR_BIT_ACMP0];
      end
   end

   // Counter zero
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_gp_counter_zero_reset <= 1'b0;
      end else begin
         o_gp_counter_zero_reset <= periph_val[`PSR_BIT_CNT0];
      end
   end

   // Counter one
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_gp_counter_one_reset <= 1'b0;
      end else begin
         o_gp_counter_one_reset <= periph_val[`PSR_BIT_CNT1];
      end
   end

   // Counter two
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_gp_counter_two_reset <= 1'b0;
      end else begin
         o_gp_counter_two_reset <= periph_val[`PSR_BIT_CNT2];
      end
   end

   // Encoder unit
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_encoder_unit_reset <= 1'b0;
      end else begin
         o_encoder_unit_reset <= periph_val[`PSR_BIT_ENC0];
      end
   end

   // Sync serial zero
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_sync_serial_zero_reset <= 1'b0;
      end else begin
         o_sync_serial_zero_reset <= periph_val[`PSR_BIT_SYNC0];
      end
   end

   // Async serial one
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_async_serial_one_reset <= 1'b0;
      end else begin
         o_async_serial_one_reset <= periph_val[`PSR_BIT_ASYNC1];
      end
   end

   // Async serial zero
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_async_serial_zero_reset <= 1'b0;
      end else begin
         o_async_serial_zero_reset <= periph_val[`PSR_BIT_ASYNC0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Port resets, one flop per port
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         port_a_q <= 1'b0;
      end else begin
         port_a_q <= port_val[`PSR_BIT_PORT_A];
      end
   end

   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         port_b_q <= 1'b0;
      end else begin
         port_b_q <= port_val[`PSR_BIT_PORT_B];
      end
   end

   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         port_c_q <= 1'b0;
      end else begin
         port_c_q <= port_val[`PSR_BIT_PORT_C];
      end
   end

   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         port_d_q <= 1'b0;
      end else begin
         port_d_q <= port_val[`PSR_BIT_PORT_D];
      end
   end

   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         port_e_q <= 1'b0;
      end else begin
         port_e_q <= port_val[`PSR_BIT_PORT_E];
      end
   end

   // Port E in the top bit down to port A in bit 0
   assign o_io_port_reset = {port_e_q, port_d_q, port_c_q, port_b_q, port_a_q};

   ////////////////////////////////////////////////////////////////////////////
   // Read mux; reserved bits are already zero in the stored values
   always_comb begin
      hit      = 1'b1;
      prdata_d = 32'h0000_0000;
      unique case (addr)
         `PSR_OFS_PERIPH_RST: prdata_d = periph_val;
         `PSR_OFS_PORT_RST:   prdata_d = port_val;
         `PSR_OFS_CAP_B:      prdata_d = capability_mask_b_q;
         `PSR_OFS_CAP_D:      prdata_d = capability_mask_d_q;
         default:             hit      = 1'b0;
      endcase
   end

   // Read data captured at setup, held through access phase
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_prdata <= 32'h0000_0000;
      end else if (rd_en) begin
         o_prdata <= prdata_d;
      end
   end

   // Error flagged for unmapped addresses in the access phase
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_pslverr <= 1'b0;
      end else begin
         o_pslverr <= i_psel && !i_penable && !hit;
      end
   end

   // Ready during every access phase, no wait states
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_pready <= 1'b0;
      end else begin
         o_pready <= i_psel && !i_penable;
      end
   end
endmodule : psr_top
`default_nettype wire

/* File: bench/psr_assertions.sv */
// Checker: port-level assertions on the soft reset bank
// Assumes binding into psr_top; capability registers writable
`timescale 1ns/1ps
`default_nettype none
`include "psr_defs.svh"
module psr_assertions (
   // Clock, reset and bus
   input wire logic        i_core_clk,
   input wire logic        i_nrst,
   input wire logic        i_psel,
   input wire logic        i_penable,
   input wire logic        i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [31:0] o_prdata,
   input wire logic        o_pready,
   input wire logic        o_pslverr,
   // Unit resets
   input wire logic        o_comparator_zero_reset,
   input wire logic        o_gp_counter_zero_reset,
   input wire logic        o_gp_counter_one_reset,
   input wire logic        o_gp_counter_two_reset,
   input wire logic        o_encoder_unit_reset,
   input wire logic        o_sync_serial_zero_reset,
   input wire logic        o_async_serial_one_reset,
   input wire logic        o_async_serial_zero_reset,
   input wire logic [4:0]  o_io_port_reset
);
   logic        acc, wr44, wr48;
   logic [9:0]  idx;
   logic [31:0] cb_q, cd_q, eb_q, ed_q, pv;
   assign idx  = i_paddr[11:2];
   assign acc  = i_psel && i_penable && o_pready && !o_pslverr;
   assign wr44 = acc && i_pwrite && idx == 10'h011;
   assign wr48 = acc && i_pwrite && idx == 10'h012;
   assign pv   = {7'h00, o_comparator_zero_reset, 5'h00, o_gp_counter_two_reset,
      o_gp_counter_one_reset, o_gp_counter_zero_reset, 7'h00, o_encoder_unit_reset, 3'h0,
      o_sync_serial_zero_reset, 2'h0, o_async_serial_one_reset, o_async_serial_zero_reset};
   ////////////////////////////////////////////////////////////
   // Mirror of capabilities and expected register values
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cb_q <= `PSR_CAP_B_DEFAULT;
         cd_q <= `PSR_CAP_D_DEFAULT;
         eb_q <= `PSR_RESET_VAL;
         ed_q <= `PSR_RESET_VAL;
      end else if (acc && i_pwrite) begin
         if (idx == 10'h013) cb_q <= i_pwdata & `PSR_CAP_B_DEFAULT;
         if (idx == 10'h014) cd_q <= i_pwdata & `PSR_CAP_D_DEFAULT;
         if (wr44) eb_q <= i_pwdata & cb_q & `PSR_PERIPH_RW_MASK;
         if (wr48) ed_q <= i_pwdata & cd_q & `PSR_PORT_RW_MASK;
      end
   end
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_nrst);
   mask_b_a: assert property (wr44 |-> ##[1:2] pv == eb_q)
      else $error("unit resets differ from masked write");
   mask_d_a: assert property (wr48 |-> ##[1:2] o_io_port_reset == ed_q[4:0])
      else $error("port resets differ from masked write");
   reset_zero_a: assert property ($rose(i_nrst) |-> pv == 32'h0 && o_io_port_reset == 5'h00)
      else $error("resets not clear after reset");
   ssi_clear_a: assert property (wr44 && !i_pwdata[4] |-> ##[1:2] !o_sync_serial_zero_reset)
      else $error("sync serial reset stuck");
   async_one_a: assert property (wr44 && !i_pwdata[1] |-> ##[1:2] !o_async_serial_one_reset)
      else $error("async serial one reset stuck");
   async_zero_a: assert property (wr44 && !i_pwdata[0] |-> ##[1:2] !o_async_serial_zero_reset)
      else $error("async serial zero reset stuck");
   rsv_read_a: assert property (acc && !i_pwrite && idx == 10'h012 |-> o_prdata[31:5] == 27'h0)
      else $error("port register reserved bits not zero");
   timer_clear_a: assert property (wr44 && i_pwdata[18:16] == 3'h0 |-> ##[1:2] pv[18:16] == 3'h0)
      else $error("timer resets stuck");
   idle_hold_a: assert property ((!wr44 && !wr48) [*3] |-> $stable(pv) && $stable(o_io_port_reset))
      else $error("unit reset changed without a write");
   cover property (wr44);
   cover property (wr48);
   cover property (o_pready && o_pslverr);
endmodule : psr_assertions
`default_nettype wire

/* File: bench/tb_top.sv */
// Testbench: APB scenarios for the soft reset bank
// Assumes psr_top and psr_assertions compiled before it
`timescale 1ns/1ps
`default_nettype none
`include "psr_defs.svh"
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin bad_count++; \
   $display("[FAIL] %s expected %h seen %h", n, e, a); end end
module tb_top;
   logic        i_core_clk = 1'b0;
   logic        i_nrst = 1'b0, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
   logic [11:0] i_paddr = 12'h000;
   logic [31:0] i_pwdata = 32'h0, o_prdata, rd;
   logic        o_pready, o_pslverr, er, o_comparator_zero_reset, o_gp_counter_zero_reset;
   logic        o_gp_counter_one_reset, o_gp_counter_two_reset, o_encoder_unit_reset;
   logic        o_sync_serial_zero_reset, o_async_serial_one_reset, o_async_serial_zero_reset;
   logic [4:0]  o_io_port_reset;
   int          bad_count = 0, num_checks = 0;
   psr_top uut (.*);
   always #12.5 i_core_clk = ~i_core_clk;
   function automatic logic [31:0] pv();
      return {7'h00, o_comparator_zero_reset, 5'h00, o_gp_counter_two_reset,
         o_gp_counter_one_reset, o_gp_counter_zero_reset, 7'h00, o_encoder_unit_reset, 3'h0,
         o_sync_serial_zero_reset, 2'h0, o_async_serial_one_reset, o_async_serial_zero_reset};
   endfunction : pv
   ////////////////////////////////////////////////////////////
   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : conclude
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      i_psel <= 1'b1;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_core_clk);
      i_penable <= 1'b1;
      for (n = 0; n < 16; n++) begin
         @(posedge i_core_clk);
         if (o_pready === 1'b1) break;
      end
      rd = o_prdata;
      er = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
      if (n == 16) begin
         bad_count++;
         conclude();
      end
      @(posedge i_core_clk);
   endtask : apb
   task automatic t_periph();
      `CHK("units after reset", 32'h0, pv())
      `CHK("ports after reset", 5'h00, o_io_port_reset)
      apb(1'b1, 12'h044, 32'hffff_ffff);
      apb(1'b0, 12'h044, 32'h0);
      `CHK("periph reg", `PSR_PERIPH_RW_MASK, rd)
      `CHK("mapped err", 1'b0, er)
      `CHK("unit resets", `PSR_PERIPH_RW_MASK, pv())
      apb(1'b1, 12'h044, 32'h0);
      @(posedge i_core_clk);
      `CHK("units freed", 32'h0, pv())
      $display("test periph done");
   endtask : t_periph
   task automatic t_mask();
      apb(1'b1, 12'h04c, 32'h0000_0010);
      apb(1'b1, 12'h050, 32'h0000_0005);
      apb(1'b1, 12'h044, 32'hffff_ffff);
      apb(1'b1, 12'h048, 32'hffff_ffff);
      apb(1'b0, 12'h044, 32'h0);
      `CHK("masked periph", 32'h0000_0010, rd)
      apb(1'b0, 12'h048, 32'h0);
      `CHK("masked ports", 32'h0000_0005, rd)
      `CHK("masked pins", 5'h05, o_io_port_reset)
      apb(1'b1, 12'h04c, `PSR_CAP_B_DEFAULT);
      apb(1'b1, 12'h050, `PSR_CAP_D_DEFAULT);
      $display("test mask done");
   endtask : t_mask
   task automatic t_port();
      apb(1'b1, 12'h048, 32'hffff_ffea);
      apb(1'b0, 12'h048, 32'h0);
      `CHK("port reg", 32'h0000_000a, rd)
      apb(1'b1, 12'h048, (rd & 32'hffff_fffd) | 32'h0000_0010);
      apb(1'b0, 12'h048, 32'h0);
      `CHK("port rmw", 32'h0000_0018, rd)
      `CHK("port pins", 5'h18, o_io_port_reset)
      apb(1'b1, 12'h0f0, 32'hffff_ffff);
      `CHK("unmapped err", 1'b1, er)
      apb(1'b0, 12'h044, 32'h0);
      `CHK("periph kept", 32'h0000_0010, rd)
      $display("test port done");
   endtask : t_port
   initial begin
      repeat (20) @(posedge i_core_clk);
      i_nrst <= 1'b1;
      @(posedge i_core_clk);
      t_periph();
      t_mask();
      t_port();
      conclude();
   end
endmodule : tb_top
bind psr_top psr_assertions chk (.*);
`default_nettype wire
